// ---- rtl/enet_event_enable_accept_map.sv ----
// Status and control register bank of the Ethernet port: interrupt
// enables, event registers, counters and receive acceptance.
// Assumes the MAC side gives one-cycle event pulses on sys_clk and that
// the host reaches the bank as 16-bit words through the data port.
//
// Overview of operation
// [RULE1] One interrupt enable per event, in receive, transmit and buffer config registers; the bank gives the BUF_SWINT event no enable.
// [RULE2] Miss and collision counters passing 1FFh raise an interrupt when enabled.
// [RULE3] Receive control register holds nine frame acceptance bits.
// [RULE4] Frames whose category acceptance bit is clear are discarded, others kept; the bank also discards frames that match no enabled destination class.
// [RULE5] The four paired acceptance and receive enable bits act independently.
// [RULE6] Enabled but not accepted receive event interrupts, rejects frame, length zero.
// [RULE7] The other five acceptance bits steer destination address filtering.
// [RULE8] Host writes zero to every reserved bit.
// [RULE9] Registers decode as 16-bit words at fixed offsets; events read-only.
// [RULE10] Enabled bit plus its event gives an interrupt to the host; the bank also needs master_irq bit 15 set.
// [RULE11] Event bits set regardless of enables and clear when read.
// [RULE12] Miss and collision counters are 10 bits and clear when read.
// [RULE13] Interrupt output is OR of all enabled pending events and overflows; the bank also ORs in BUF_SWINT with no enable and gates with master_irq bit 15.
// [RULE14] Reserved locations read zero and ignore writes.
`include "enet_regs_map.svh"
`timescale 1ns/100ps
`default_nettype none

module enet_event_enable_accept_map (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire enet_regs_pkg::offset_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire enet_regs_pkg::word_t reg_wdata,
   output enet_regs_pkg::word_t reg_rdata,
   input wire logic rx_done,
   input wire logic [3:0] rx_category,
   input wire logic [4:0] rx_dest_class,
   input wire enet_regs_pkg::word_t rx_frame_len,
   input wire logic [4:0] tx_event_in,
   input wire logic [4:0] buf_event_in,
   input wire logic [9:0] line_status_in,
   input wire logic [9:0] self_status_in,
   output logic rx_keep,
   output logic rx_reject,
   output enet_regs_pkg::word_t rx_length,
   output logic [4:0] dest_filter_accept,
   output logic [15:0] line_control_out,
   output logic irq
);
   import enet_regs_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      word_t master_irq;
      word_t ee_cmd;
      word_t ee_data;
      word_t rx_bytes;
      word_t rx_cfg;
      word_t rx_ctl;
      word_t tx_cfg;
      word_t buf_cfg;
      word_t line_ctl;
      word_t self_ctl;
      word_t bus_ctl;
      word_t test_ctl;
      word_t rx_evt;
      word_t tx_evt;
      word_t buf_evt;
      count_t miss_cnt;
      count_t col_cnt;
      word_t rdata;
      logic keep;
      logic reject;
      word_t len;
      logic irq;
   } bank_t;

   bank_t cur;
   bank_t next_cur;

   word_t rd_value;
   logic [4:0] rd_clear;
   logic [3:0] rx_set;
   logic [3:0] rx_accept4;
   logic [4:0] rx_accept5;
   logic frame_ok;
   word_t rx_set_w;
   word_t tx_set_w;
   word_t buf_set_w;
   logic irq_pending;

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   // rd_clear: rx, tx, buf events, miss, collision counters
   always_comb begin
      rd_value = 16'h0000;
      rd_clear = 5'h00;
      // [RULE9] Fixed word decode
      case (reg_addr)
         `OFS_MASTER_IRQ: rd_value = cur.master_irq;
         `OFS_EE_CMD: rd_value = cur.ee_cmd;
         `OFS_EE_DATA: rd_value = cur.ee_data;
         `OFS_RX_BYTES: rd_value = cur.rx_bytes;
         `OFS_RX_CFG: rd_value = cur.rx_cfg | `CODE_RX_CFG;
         `OFS_RX_CTL: rd_value = cur.rx_ctl | `CODE_RX_CTL;
         `OFS_TX_CFG: rd_value = cur.tx_cfg | `CODE_TX_CFG;
         `OFS_TX_CMD: rd_value = `CODE_TX_CMD;
         `OFS_BUF_CFG: rd_value = cur.buf_cfg | `CODE_BUF_CFG;
         `OFS_LINE_CTL: rd_value = cur.line_ctl | `CODE_LINE_CTL;
         `OFS_SELF_CTL: rd_value = cur.self_ctl | `CODE_SELF_CTL;
         `OFS_BUS_CTL: rd_value = cur.bus_ctl | `CODE_BUS_CTL;
         `OFS_TEST_CTL: rd_value = cur.test_ctl | `CODE_TEST_CTL;
         // [RULE11] Read clears events
         `OFS_RX_EVT: begin
            rd_value = cur.rx_evt | `CODE_RX_EVT;
            rd_clear = 5'h01;
         end
         `OFS_TX_EVT: begin
            rd_value = cur.tx_evt | `CODE_TX_EVT;
            rd_clear = 5'h02;
         end
         `OFS_BUF_EVT: begin
            rd_value = cur.buf_evt | `CODE_BUF_EVT;
            rd_clear = 5'h04;
         end
         // [RULE12] Counters clear on read
         `OFS_MISS_CNT: begin
            rd_value = {cur.miss_cnt, 6'h00} | `CODE_MISS_CNT;
            rd_clear = 5'h08;
         end
         `OFS_COL_CNT: begin
            rd_value = {cur.col_cnt, 6'h00} | `CODE_COL_CNT;
            rd_clear = 5'h10;
         end
         `OFS_LINE_ST: rd_value = {line_status_in, 6'h00} | `CODE_LINE_ST;
         `OFS_SELF_ST: rd_value = {self_status_in, 6'h00} | `CODE_SELF_ST;
         // Queue hands out the first non-empty event register and drains it
         `OFS_ISQ: begin
            if (cur.rx_evt != 16'h0000) begin
               rd_value = cur.rx_evt | `CODE_RX_EVT;
               rd_clear = 5'h01;
            end else if (cur.tx_evt != 16'h0000) begin
               rd_value = cur.tx_evt | `CODE_TX_EVT;
               rd_clear = 5'h02;
            end else if (cur.buf_evt != 16'h0000) begin
               rd_value = cur.buf_evt | `CODE_BUF_EVT;
               rd_clear = 5'h04;
            end else if (cur.miss_cnt[`CNT_WRAP_BIT]) begin
               rd_value = {cur.miss_cnt, 6'h00} | `CODE_MISS_CNT;
               rd_clear = 5'h08;
            end else if (cur.col_cnt[`CNT_WRAP_BIT]) begin
               rd_value = {cur.col_cnt, 6'h00} | `CODE_COL_CNT;
               rd_clear = 5'h10;
            end
         end
         // [RULE14] Unmapped reads zero
         default: rd_value = 16'h0000;
      endcase
      if (!reg_rd) begin
         rd_clear = 5'h00;
      end
   end

   // ----------------------------------------
   // Receive acceptance and event set vectors
   // ----------------------------------------
   always_comb begin
      // [RULE3] Nine acceptance bits
      rx_accept4 = {cur.rx_ctl[`RX_EXTRA], cur.rx_ctl[`RX_RUNT], cur.rx_ctl[`RX_FCS],
                    cur.rx_ctl[`RX_GOOD]};
      // [RULE7] Address filter bits
      rx_accept5 = {cur.rx_ctl[`RX_DEST_UP_MSB:`RX_DEST_UP_LSB],
                    cur.rx_ctl[`RX_DEST_LO_MSB:`RX_DEST_LO_LSB]};
      rx_set = rx_done ? rx_category : 4'h0;
      // [RULE4] Discard unaccepted categories
      frame_ok = ((rx_category & rx_accept4) != 4'h0) &&
                 ((rx_dest_class & rx_accept5) != 5'h00);
      // [RULE5] Events ignore acceptance
      rx_set_w = 16'h0000;
      rx_set_w[`RX_EXTRA] = rx_set[3];
      rx_set_w[`RX_RUNT] = rx_set[2];
      rx_set_w[`RX_FCS] = rx_set[1];
      rx_set_w[`RX_GOOD] = rx_set[0];
      tx_set_w = 16'h0000;
      tx_set_w[`TX_SIXTEEN] = tx_event_in[4];
      tx_set_w[`TX_ANY_COL] = tx_event_in[3];
      tx_set_w[`TX_OVERLONG] = tx_event_in[2];
      tx_set_w[`TX_LATE] = tx_event_in[1];
      tx_set_w[`TX_GOOD] = tx_event_in[0];
      buf_set_w = 16'h0000;
      buf_set_w[`BUF_RX_DEST] = buf_event_in[4];
      buf_set_w[`BUF_RX_CHUNK] = buf_event_in[3];
      buf_set_w[`BUF_RX_DROP] = buf_event_in[2];
      buf_set_w[`BUF_TX_STARVE] = buf_event_in[1];
      buf_set_w[`BUF_TX_SPACE] = buf_event_in[0];
      buf_set_w[`BUF_SWINT] = reg_wr && (reg_addr == `OFS_BUF_CFG) && reg_wdata[`BUF_SWINT];
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.rdata = reg_rd ? rd_value : cur.rdata;
      // Masking keeps reserved bits zero in the config and control registers even if the host breaks [RULE8]
      if (reg_wr) begin
         case (reg_addr)
            `OFS_MASTER_IRQ: next_cur.master_irq = reg_wdata;
            `OFS_EE_CMD: next_cur.ee_cmd = reg_wdata;
            `OFS_EE_DATA: next_cur.ee_data = reg_wdata;
            // [RULE1] Enable registers, plus receive control and the other control registers
            `OFS_RX_CFG: next_cur.rx_cfg = reg_wdata & `RX_IRQ_MASK;
            `OFS_RX_CTL: next_cur.rx_ctl = reg_wdata & `RX_CTL_MASK;
            `OFS_TX_CFG: next_cur.tx_cfg = reg_wdata & `TX_IRQ_MASK;
            `OFS_BUF_CFG: next_cur.buf_cfg = reg_wdata & `BUF_CFG_MASK;
            `OFS_LINE_CTL: next_cur.line_ctl = reg_wdata & `CTL_BODY_MASK;
            `OFS_SELF_CTL: next_cur.self_ctl = reg_wdata & `CTL_BODY_MASK;
            `OFS_BUS_CTL: next_cur.bus_ctl = reg_wdata & `CTL_BODY_MASK;
            `OFS_TEST_CTL: next_cur.test_ctl = reg_wdata & `CTL_BODY_MASK;
            // [RULE14] Other writes ignored
            default: next_cur.master_irq = cur.master_irq;
         endcase
      end
      // [RULE11] Set wins over read clear
      next_cur.rx_evt = (rd_clear[0] ? 16'h0000 : cur.rx_evt) | rx_set_w;
      next_cur.tx_evt = (rd_clear[1] ? 16'h0000 : cur.tx_evt) | tx_set_w;
      next_cur.buf_evt = (rd_clear[2] ? 16'h0000 : cur.buf_evt) | buf_set_w;
      // [RULE12] Ten-bit counters, saturating
      next_cur.miss_cnt = rd_clear[3] ? 10'h000 : cur.miss_cnt;
      if (buf_event_in[2] && (next_cur.miss_cnt != 10'h3ff)) begin
         next_cur.miss_cnt = next_cur.miss_cnt + 10'h001;
      end
      next_cur.col_cnt = rd_clear[4] ? 10'h000 : cur.col_cnt;
      if (tx_event_in[3] && (next_cur.col_cnt != 10'h3ff)) begin
         next_cur.col_cnt = next_cur.col_cnt + 10'h001;
      end
      // [RULE6] Reject gives zero length
      next_cur.keep = rx_done && frame_ok;
      next_cur.reject = rx_done && !frame_ok;
      if (rx_done) begin
         next_cur.len = frame_ok ? rx_frame_len : 16'h0000;
         next_cur.rx_bytes = frame_ok ? rx_frame_len : 16'h0000;
      end
      // [RULE10] Enabled events interrupt
      // [RULE2] Counter overflow past 1FFh
      irq_pending = ((cur.rx_evt & cur.rx_cfg) != 16'h0000) ||
                    ((cur.tx_evt & cur.tx_cfg) != 16'h0000) ||
                    ((cur.buf_evt & cur.buf_cfg & `BUF_IRQ_MASK) != 16'h0000) ||
                    cur.buf_evt[`BUF_SWINT] ||
                    (cur.buf_cfg[`BUF_MISS_WRAP] && cur.miss_cnt[`CNT_WRAP_BIT]) ||
                    (cur.buf_cfg[`BUF_COL_WRAP] && cur.col_cnt[`CNT_WRAP_BIT]);
      // [RULE13] Gated OR of pending
      next_cur.irq = irq_pending && cur.master_irq[`MASTER_IRQ_BIT];
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Synchronous reset keeps every output flop defined from the first edge
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign reg_rdata = cur.rdata;
   assign rx_keep = cur.keep;
   assign rx_reject = cur.reject;
   assign rx_length = cur.len;
   assign dest_filter_accept = rx_accept5;
   assign line_control_out = cur.line_ctl;
   assign irq = cur.irq;

endmodule

`default_nettype wire

// ---- common/enet_regs_map.svh ----
// Offsets, register codes, field positions and write masks of the
// Ethernet port status/control bank. Definitions only.
`ifndef ENET_REGS_MAP_SVH
`define ENET_REGS_MAP_SVH
// ----------------------------------------
// Offsets in the 4 Kbyte page
// ----------------------------------------
`define OFS_MASTER_IRQ 12'h022
`define OFS_EE_CMD 12'h040
`define OFS_EE_DATA 12'h042
`define OFS_RX_BYTES 12'h050
`define OFS_RX_CFG 12'h102
`define OFS_RX_CTL 12'h104
`define OFS_TX_CFG 12'h106
`define OFS_TX_CMD 12'h108
`define OFS_BUF_CFG 12'h10a
`define OFS_LINE_CTL 12'h112
`define OFS_SELF_CTL 12'h114
`define OFS_BUS_CTL 12'h116
`define OFS_TEST_CTL 12'h118
`define OFS_ISQ 12'h120
`define OFS_RX_EVT 12'h124
`define OFS_TX_EVT 12'h128
`define OFS_BUF_EVT 12'h12c
`define OFS_MISS_CNT 12'h130
`define OFS_COL_CNT 12'h132
`define OFS_LINE_ST 12'h134
`define OFS_SELF_ST 12'h136
// ----------------------------------------
// Register codes in bits 5:0
// ----------------------------------------
`define CODE_RX_CFG 16'h0003
`define CODE_RX_CTL 16'h0005
`define CODE_TX_CFG 16'h0007
`define CODE_TX_CMD 16'h0009
`define CODE_BUF_CFG 16'h000b
`define CODE_LINE_CTL 16'h0013
`define CODE_SELF_CTL 16'h0015
`define CODE_BUS_CTL 16'h0017
`define CODE_TEST_CTL 16'h0019
`define CODE_RX_EVT 16'h0004
`define CODE_TX_EVT 16'h0008
`define CODE_BUF_EVT 16'h000c
`define CODE_MISS_CNT 16'h0010
`define CODE_COL_CNT 16'h0012
`define CODE_LINE_ST 16'h0014
`define CODE_SELF_ST 16'h0016
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define RX_EXTRA 14
`define RX_RUNT 13
`define RX_FCS 12
`define RX_GOOD 8
`define RX_DEST_UP_MSB 11
`define RX_DEST_UP_LSB 9
`define RX_DEST_LO_MSB 7
`define RX_DEST_LO_LSB 6
`define RX_IRQ_MASK 16'h7100
`define RX_CTL_MASK 16'h7fc0
`define TX_GOOD 8
`define TX_LATE 9
`define TX_OVERLONG 10
`define TX_ANY_COL 11
`define TX_SIXTEEN 15
`define TX_IRQ_MASK 16'h8f00
`define BUF_SWINT 6
`define BUF_TX_SPACE 8
`define BUF_TX_STARVE 9
`define BUF_RX_DROP 10
`define BUF_RX_CHUNK 11
`define BUF_MISS_WRAP 12
`define BUF_COL_WRAP 13
`define BUF_RX_DEST 15
`define BUF_IRQ_MASK 16'h8f00
`define BUF_CFG_MASK 16'hbf00
`define CTL_BODY_MASK 16'hffc0
`define CNT_LSB 6
`define CNT_WRAP_BIT 9
`define MASTER_IRQ_BIT 15
`endif

// ---- common/enet_regs_pkg.sv ----
// Types shared by the Ethernet port register bank.
// Assumes enet_regs_map.svh supplies the numeric layout.
package enet_regs_pkg;
   typedef logic [15:0] word_t;
   typedef logic [11:0] offset_t;
   typedef logic [9:0] count_t;
endpackage

// ---- verif/enet_bank_monitor.sv ----
// Assertion checker for the Ethernet register bank ports.
// Assumes it is bound into enet_event_enable_accept_map.
`timescale 1ns/100ps
`default_nettype none
`include "enet_regs_map.svh"
module enet_bank_monitor (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic rx_done,
   input wire logic [4:0] rx_dest_class,
   input wire logic [15:0] rx_frame_len,
   input wire logic [4:0] tx_event_in,
   input wire logic [4:0] buf_event_in,
   input wire logic rx_keep,
   input wire logic rx_reject,
   input wire logic [15:0] rx_length,
   input wire logic [4:0] dest_filter_accept,
   input wire logic irq
);
   // ----------------------------------------
   // Frame outcome, register port, interrupt
   // ----------------------------------------
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_kept;
      rx_done ##1 rx_keep;
   endsequence
   a_one_outcome: assert property (rx_done |=> rx_keep ^ rx_reject)
      else $error("frame outcome not single");
   a_kept_length: assert property (s_kept |-> rx_length == $past(rx_frame_len))
      else $error("kept length wrong");
   a_reject_zero: assert property (rx_reject |-> rx_length == 16'h0000)
      else $error("rejected length not zero");
   a_outcome_cause: assert property (rx_keep || rx_reject |-> $past(rx_done))
      else $error("outcome without frame");
   a_dest_gate: assert property (rx_done && (rx_dest_class & dest_filter_accept) == 5'h00
      |=> rx_reject) else $error("unmatched destination kept");
   a_dest_copy: assert property (reg_wr && reg_addr == `OFS_RX_CTL |=>
      dest_filter_accept == {$past(reg_wdata[11:9]), $past(reg_wdata[7:6])})
      else $error("destination accept copy wrong");
   a_code_view: assert property (reg_rd && reg_addr == `OFS_TX_CMD |=>
      reg_rdata == `CODE_TX_CMD) else $error("command view wrong");
   a_irq_cause: assert property ($rose(irq) |->
      $past(reg_wr || rx_done || (|tx_event_in) || (|buf_event_in), 2))
      else $error("interrupt without cause");
   a_irq_drop: assert property ($fell(irq) |-> $past(reg_rd || reg_wr, 2))
      else $error("interrupt dropped without access");
endmodule
bind enet_event_enable_accept_map enet_bank_monitor mon_u (.sys_clk, .reset_n, .reg_addr,
   .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rx_done, .rx_dest_class, .rx_frame_len,
   .tx_event_in, .buf_event_in, .rx_keep, .rx_reject, .rx_length, .dest_filter_accept, .irq);
`default_nettype wire

// ---- verif/enet_host_model.sv ----
// Host processor model: 16-bit word cycles on the register port.
// Assumes the bank samples strobes on the rising edge of sys_clk.
`timescale 1ns/100ps
`default_nettype none
module enet_host_model (
   input wire logic sys_clk,
   input wire logic [15:0] reg_rdata,
   output logic [11:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata
);
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   initial begin
      reg_addr = 12'h000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // Reserved bits zero: callers pass only defined bits, except t_regs writing FFFFh to unmapped offset 200h
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk) #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // Released address is inverted so a stale value is never mistaken
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge sys_clk) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk) #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ---- verif/enet_event_enable_accept_map_tb_top.sv ----
// Self-checking bench of the Ethernet register bank.
// Assumes the host model drives the register port, the bench the MAC side.
`timescale 1ns/100ps
`default_nettype none
`include "enet_regs_map.svh"
module enet_event_enable_accept_map_tb_top;
   import enet_regs_pkg::*;
   localparam word_t flen = 16'h05ee;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   offset_t reg_addr;
   logic reg_wr;
   logic reg_rd;
   word_t reg_wdata;
   word_t reg_rdata;
   logic rx_done = 1'b0;
   logic [3:0] rx_category = 4'h0;
   logic [4:0] rx_dest_class = 5'h00;
   word_t rx_frame_len = 16'h0000;
   logic [4:0] tx_event_in = 5'h00;
   logic [4:0] buf_event_in = 5'h00;
   logic [9:0] line_status_in = 10'h2a5;
   logic [9:0] self_status_in = 10'h15a;
   logic rx_keep;
   logic rx_reject;
   word_t rx_length;
   logic [4:0] dest_filter_accept;
   logic [15:0] line_control_out;
   logic irq;
   int err_count = 0;
   int cmp_count = 0;
   always #12.5 sys_clk = ~sys_clk;
   enet_event_enable_accept_map dut_u (.sys_clk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .rx_done, .rx_category, .rx_dest_class, .rx_frame_len,
      .tx_event_in, .buf_event_in, .line_status_in, .self_status_in, .rx_keep,
      .rx_reject, .rx_length, .dest_filter_accept, .line_control_out, .irq);
   enet_host_model host_u (.sys_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input word_t e);
      word_t d;
      host_u.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic ev(input logic [3:0] c, input logic [4:0] d, t, b);
      @(posedge sys_clk) #1;
      rx_done = |c;
      rx_category = c;
      rx_dest_class = d;
      rx_frame_len = flen;
      tx_event_in = t;
      buf_event_in = b;
      @(posedge sys_clk) #1;
      rx_done = 1'b0;
      rx_category = ~c;
      rx_dest_class = ~d;
      rx_frame_len = ~flen;
      tx_event_in = 5'h00;
      buf_event_in = 5'h00;
   endtask
   task automatic outcome(input logic k, input word_t len);
      chk("rx_keep", {15'h0000, k}, {15'h0000, rx_keep});
      chk("rx_reject", {15'h0000, ~k}, {15'h0000, rx_reject});
      chk("rx_length", len, rx_length);
   endtask
   // Two cycles of interrupt latency, one spare
   task automatic idle_irq;
      repeat (3) @(posedge sys_clk) #1;
      chk("irq", 16'h0000, {15'h0000, irq});
   endtask
   task automatic wait_irq(input logic e);
      for (int i = 0; i < 4 && irq !== e; i++) begin
         @(posedge sys_clk) #1;
      end
      chk("irq", {15'h0000, e}, {15'h0000, irq});
      if (irq !== e) begin
         conclude;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      offset_t o [5] = '{`OFS_RX_CFG, `OFS_RX_CTL, `OFS_TX_CFG, `OFS_BUF_CFG, `OFS_LINE_CTL};
      word_t m [5] = '{`RX_IRQ_MASK, `RX_CTL_MASK, `TX_IRQ_MASK, `BUF_CFG_MASK, `CTL_BODY_MASK};
      word_t c [5] = '{`CODE_RX_CFG, `CODE_RX_CTL, `CODE_TX_CFG, `CODE_BUF_CFG, `CODE_LINE_CTL};
      chk("irq", 16'h0000, {15'h0000, irq});
      rchk(`OFS_LINE_ST, {line_status_in, 6'h14});
      rchk(`OFS_SELF_ST, {self_status_in, 6'h16});
      rchk(`OFS_ISQ, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         rchk(o[i], c[i]);
         host_u.wr(o[i], m[i]);
         rchk(o[i], m[i] | c[i]);
         if (i == 4) begin
            chk("line_ctl", m[i], line_control_out & m[i]);
         end
         host_u.wr(o[i], 16'h0000);
      end
      host_u.wr(12'h200, 16'hffff);
      rchk(12'h200, 16'h0000);
      host_u.wr(`OFS_TX_CMD, `CTL_BODY_MASK);
      rchk(`OFS_TX_CMD, `CODE_TX_CMD);
      host_u.wr(`OFS_RX_EVT, `RX_IRQ_MASK);
      rchk(`OFS_RX_EVT, `CODE_RX_EVT);
      $display("t_regs done");
   endtask
   task automatic t_rx;
      int b [4] = '{`RX_EXTRA, `RX_RUNT, `RX_FCS, `RX_GOOD};
      word_t m;
      host_u.wr(`OFS_MASTER_IRQ, 16'h8000);
      for (int i = 0; i < 4; i++) begin
         m = 16'h0001 << b[i];
         host_u.wr(`OFS_RX_CFG, 16'h0000);
         host_u.wr(`OFS_RX_CTL, m | 16'h0040);
         ev(4'h8 >> i, 5'h01, 5'h00, 5'h00);
         outcome(1'b1, flen);
         rchk(`OFS_RX_BYTES, flen);
         ev(4'h8 >> i, 5'h02, 5'h00, 5'h00);
         outcome(1'b0, 16'h0000);
         idle_irq;
         rchk(`OFS_RX_EVT, m | `CODE_RX_EVT);
         host_u.wr(`OFS_RX_CFG, m);
         host_u.wr(`OFS_RX_CTL, 16'h0040);
         ev(4'h8 >> i, 5'h01, 5'h00, 5'h00);
         outcome(1'b0, 16'h0000);
         wait_irq(1'b1);
         rchk(`OFS_RX_EVT, m | `CODE_RX_EVT);
         wait_irq(1'b0);
      end
      host_u.wr(`OFS_RX_CFG, 16'h0000);
      $display("t_rx done");
   endtask
   task automatic t_events;
      int b [5] = '{8, 9, 10, 11, 15};
      word_t m;
      for (int k = 0; k < 10; k++) begin
         m = 16'h0001 << b[k % 5];
         host_u.wr(k < 5 ? `OFS_TX_CFG : `OFS_BUF_CFG, m);
         ev(4'h0, 5'h00, k < 5 ? 5'h01 << k : 5'h00, k < 5 ? 5'h00 : 5'h01 << (k - 5));
         wait_irq(1'b1);
         rchk(k < 5 ? `OFS_TX_EVT : `OFS_BUF_EVT, m | (k < 5 ? 16'h0008 : 16'h000c));
         wait_irq(1'b0);
         host_u.wr(k < 5 ? `OFS_TX_CFG : `OFS_BUF_CFG, 16'h0000);
      end
      // Software interrupt raises irq with no buffer enable set; queue drains transmit before buffer
      ev(4'h0, 5'h00, 5'h01, 5'h00);
      host_u.wr(`OFS_BUF_CFG, 16'h0040);
      wait_irq(1'b1);
      rchk(`OFS_BUF_CFG, `CODE_BUF_CFG);
      rchk(`OFS_ISQ, 16'h0108);
      rchk(`OFS_ISQ, 16'h004c);
      wait_irq(1'b0);
      rchk(`OFS_ISQ, 16'h0000);
      $display("t_events done");
   endtask
   task automatic t_counters;
      rchk(`OFS_MISS_CNT, 16'h0050);
      rchk(`OFS_COL_CNT, 16'h0052);
      host_u.wr(`OFS_BUF_CFG, 16'h1000);
      repeat (511) ev(4'h0, 5'h00, 5'h08, 5'h04);
      idle_irq;
      ev(4'h0, 5'h00, 5'h08, 5'h04);
      wait_irq(1'b1);
      rchk(`OFS_MISS_CNT, 16'h8010);
      wait_irq(1'b0);
      rchk(`OFS_MISS_CNT, 16'h0010);
      rchk(`OFS_COL_CNT, 16'h8012);
      host_u.wr(`OFS_BUF_CFG, 16'h0000);
      rchk(`OFS_TX_EVT, 16'h0808);
      rchk(`OFS_BUF_EVT, 16'h040c);
      $display("t_counters done");
   endtask
   task automatic conclude;
      $display("Counts: %0d compared, %0d mismatched", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      t_regs;
      t_rx;
      t_events;
      t_counters;
      conclude;
   end
endmodule
`default_nettype wire
